// *** rtl/sbu_pkg.sv ***
/*
 * package for the serial bus unit slave/stop/restart block: register
 * offsets, control and status field positions, timing counts, types.
 * assumes a 50 MHz ref_clk and a plain strobe register port.
 */
package sbu_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFS_DATA_BUF = 4'h4;
    localparam logic [3:0] OFS_CTRL_TWO = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    // own address sits at 0xe, one below the top slot 0xf; a 4-bit port cannot reach 0x10
    localparam logic [3:0] OFS_OWN_ADDR = 4'he;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_MST = 7;
    localparam int BIT_TRX = 6;
    localparam int BIT_BB = 5;
    localparam int BIT_PIN = 4;
    localparam int BIT_AL = 3;
    localparam int BIT_AAS = 2;
    localparam int BIT_ADO = 1;
    localparam int BIT_LRB = 0;
    localparam int BIT_ACK = 4;
    localparam logic [2:0] BC_RESET = 3'h0;
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TLOW_NS = 4700;
    localparam int TLOW_CYC = (TLOW_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic master;
        logic trx;
        logic busy;
        logic pin;
    } sbu_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WAIT = 3'b011,
        ST_DATA = 3'b100,
        ST_STOP = 3'b101
    } sbu_state_t;
endpackage : sbu_pkg

// *** rtl/sbu_pin_sync.sv ***
/*
 * two-flop synchroniser for the open-drain bus lines, plus edge and
 * start/stop detection on the synchronised levels.
 * assumes scl and sda inputs are asynchronous to ref_clk.
 */
`timescale 1ns/100ps
module sbu_pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclLvl,
    output logic sdaLvl,
    output logic sclRise,
    output logic sclFall,
    output logic startSeen,
    output logic stopSeen
);
    logic [1:0] sclMeta_r;
    logic [1:0] sdaMeta_r;
    logic sclOld_r;
    logic sdaOld_r;

    // ------------------------------------------------------------
    // synchronise; first stage read only by the second
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclMeta_r <= 2'h3;
            sdaMeta_r <= 2'h3;
            sclOld_r <= 1'b1;
            sdaOld_r <= 1'b1;
        end else begin
            sclMeta_r <= {sclMeta_r[0], sclIn};
            sdaMeta_r <= {sdaMeta_r[0], sdaIn};
            sclOld_r <= sclMeta_r[1];
            sdaOld_r <= sdaMeta_r[1];
        end
    end

    // edge and condition decode
    assign sclLvl = sclMeta_r[1];
    assign sdaLvl = sdaMeta_r[1];
    assign sclRise = sclMeta_r[1] & ~sclOld_r;
    assign sclFall = ~sclMeta_r[1] & sclOld_r;
    assign startSeen = sclMeta_r[1] & sclOld_r & sdaOld_r & ~sdaMeta_r[1];
    assign stopSeen = sclMeta_r[1] & sclOld_r & ~sdaOld_r & sdaMeta_r[1];
endmodule : sbu_pin_sync

// *** rtl/sbu_slave_stop.sv ***
/*
 * serial bus unit: slave side, stop generation and restart release.
 * assumes the pad turns the active-low enables into open-drain drive,
 * and software follows the documented interrupt procedures.
 */
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module sbu_slave_stop #(
    parameter int TLOW_CYCLES = sbu_pkg::TLOW_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe_n,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    output logic eventPending
);
    sbu_pkg::sbu_ctrl_t ctrl_r;
    sbu_pkg::sbu_state_t state_r;
    logic arbLost_r, addressed_r, zeroAddr_r, lastBit_r;
    logic [2:0] bitCount_r;
    logic ackMode_r;
    logic [6:0] ownAddr_r;
    logic [7:0] shift_r, dataBuf_r;
    logic [3:0] bitIdx_r;
    logic sclHold_r, sdaLow_r;
    logic [7:0] txShift_r;
    logic selected_r;
    logic [15:0] lowCnt_r;
    logic stopPend_r;
    logic [7:0] regRdata_r;
    logic sclLvl, sdaLvl, sclRise, sclFall, startSeen, stopSeen;
    logic dataTouch, ctrlWr, releaseReq;
    logic [7:0] statusWord;

    sbu_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sclLvl(sclLvl),
        .sdaLvl(sdaLvl),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startSeen(startSeen),
        .stopSeen(stopSeen)
    );

    // ------------------------------------------------------------
    // register access decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign ctrlWr = regWr && hit(regAddr, sbu_pkg::OFS_CTRL_TWO);
    assign dataTouch = (regWr || regRd) && hit(regAddr, sbu_pkg::OFS_DATA_BUF);
    assign releaseReq = dataTouch || (ctrlWr && regWdata[sbu_pkg::BIT_PIN]);
    assign statusWord = {ctrl_r.master, ctrl_r.trx, ctrl_r.busy, ctrl_r.pin,
                         arbLost_r, addressed_r, zeroAddr_r, lastBit_r};

    // read data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdata_r <= 8'h00;
        end else if (regRd) begin
            if (hit(regAddr, sbu_pkg::OFS_CTRL_ONE)) begin
                regRdata_r <= {3'h0, ackMode_r, 1'b0, bitCount_r};
            end else if (hit(regAddr, sbu_pkg::OFS_DATA_BUF)) begin
                regRdata_r <= dataBuf_r;
            end else if (hit(regAddr, sbu_pkg::OFS_STATUS)) begin
                regRdata_r <= statusWord;
            end else if (hit(regAddr, sbu_pkg::OFS_OWN_ADDR)) begin
                regRdata_r <= {ownAddr_r, 1'b0};
            end else begin
                regRdata_r <= 8'h00;
            end
        end else begin
            regRdata_r <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // software settings
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bitCount_r <= sbu_pkg::BC_RESET;
            ackMode_r <= 1'b0;
            ownAddr_r <= sbu_pkg::OWN_ADDR_RESET;
        end else if (regWr && hit(regAddr, sbu_pkg::OFS_CTRL_ONE)) begin
            bitCount_r <= regWdata[2:0];
            ackMode_r <= regWdata[sbu_pkg::BIT_ACK];
        end else if (regWr && hit(regAddr, sbu_pkg::OFS_OWN_ADDR)) begin
            ownAddr_r <= regWdata[7:1];
        end
    end

    // ------------------------------------------------------------
    // control flags, stop request and bus busy
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= '{master: 1'b0, trx: 1'b0, busy: 1'b0, pin: 1'b1};
            stopPend_r <= 1'b0;
        end else begin
            if (ctrlWr) begin
                if (ctrl_r.busy && regWdata[sbu_pkg::BIT_MST] && regWdata[sbu_pkg::BIT_TRX]
                    && regWdata[sbu_pkg::BIT_PIN] && !regWdata[sbu_pkg::BIT_BB]) begin
                    stopPend_r <= 1'b1;
                end
                ctrl_r.master <= regWdata[sbu_pkg::BIT_MST];
                ctrl_r.trx <= regWdata[sbu_pkg::BIT_TRX];
            end
            if (releaseReq) begin
                ctrl_r.pin <= 1'b1;
            end
            if (state_r == sbu_pkg::ST_ACK && addressed_r && shift_r[0]) begin
                ctrl_r.trx <= 1'b1;
            end
            if (arbLost_r && ctrl_r.master && !ctrlWr) begin
                ctrl_r.master <= 1'b0;
            end
            // word done: interrupt pending, scl held
            if (state_r == sbu_pkg::ST_ACK && sclFall && selected_r) begin
                ctrl_r.pin <= 1'b0;
            end
            if (startSeen) begin
                ctrl_r.busy <= 1'b1;
            end else if (stopSeen) begin
                ctrl_r.busy <= 1'b0;
                stopPend_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // receive state machine: address, ack, data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= sbu_pkg::ST_IDLE;
            shift_r <= 8'h00;
            bitIdx_r <= 4'h0;
            addressed_r <= 1'b0;
            zeroAddr_r <= 1'b0;
            lastBit_r <= 1'b1;
            arbLost_r <= 1'b0;
            dataBuf_r <= 8'h00;
            selected_r <= 1'b0;
        end else begin
            if (regWr && hit(regAddr, sbu_pkg::OFS_DATA_BUF)) begin
                dataBuf_r <= regWdata;
            end
            if (startSeen) begin
                state_r <= sbu_pkg::ST_ADDR;
                bitIdx_r <= 4'h0;
                addressed_r <= 1'b0;
                zeroAddr_r <= 1'b0;
                selected_r <= 1'b0;
            end else if (stopSeen) begin
                state_r <= sbu_pkg::ST_IDLE;
                arbLost_r <= 1'b0;
                selected_r <= 1'b0;
            end else begin
                case (state_r)
                    sbu_pkg::ST_ADDR, sbu_pkg::ST_DATA: begin
                        if (sclRise) begin
                            shift_r <= {shift_r[6:0], sdaLvl};
                            bitIdx_r <= bitIdx_r + 4'h1;
                            // lost when driving high but line low
                            if (ctrl_r.master && ctrl_r.trx && !sdaLvl && shift_r[7]) begin
                                arbLost_r <= 1'b1;
                            end
                        end
                        if (sclFall && bitIdx_r == 4'h8) begin
                            state_r <= sbu_pkg::ST_ACK;
                            if (state_r == sbu_pkg::ST_ADDR) begin
                                addressed_r <= (shift_r[7:1] == ownAddr_r);
                                zeroAddr_r <= (shift_r == 8'h00);
                                // stays set for every word of this transaction
                                selected_r <= (shift_r[7:1] == ownAddr_r) || (shift_r == 8'h00);
                            end else begin
                                dataBuf_r <= shift_r;
                                addressed_r <= 1'b0;
                            end
                        end
                    end
                    sbu_pkg::ST_ACK: begin
                        if (sclRise) begin
                            lastBit_r <= sdaLvl;
                        end
                        if (sclFall) begin
                            state_r <= sbu_pkg::ST_WAIT;
                        end
                    end
                    sbu_pkg::ST_WAIT: begin
                        if (ctrl_r.pin && !sclHold_r) begin
                            state_r <= sbu_pkg::ST_DATA;
                            bitIdx_r <= 4'h0;
                        end
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // scl hold with low-period release timer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclHold_r <= 1'b0;
            lowCnt_r <= 16'h0000;
        end else if (!ctrl_r.master && !ctrl_r.pin) begin
            sclHold_r <= 1'b1;
            lowCnt_r <= 16'(TLOW_CYCLES);
        end else if (sclHold_r) begin
            if (lowCnt_r <= 16'h0001) begin
                sclHold_r <= 1'b0;
            end
            lowCnt_r <= lowCnt_r - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // sda drive: ack, stop and restart release
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sdaLow_r <= 1'b0;
            txShift_r <= 8'h00;
        end else if (stopPend_r) begin
            // wait for scl, then sda high
            sdaLow_r <= !sclLvl;
        end else if (!ctrl_r.master && !ctrl_r.trx && ctrl_r.pin && !ctrl_r.busy) begin
            sdaLow_r <= 1'b0;
        end else if (state_r == sbu_pkg::ST_WAIT && ctrl_r.trx && !ctrl_r.master
                     && ctrl_r.pin) begin
            // first bit set up while scl still held
            txShift_r <= dataBuf_r;
            sdaLow_r <= !dataBuf_r[7];
        end else if (state_r == sbu_pkg::ST_DATA && ctrl_r.trx && !ctrl_r.master) begin
            // shift out on scl low, free sda for master ack
            if (sclFall) begin
                if (bitIdx_r == 4'h8) begin
                    sdaLow_r <= 1'b0;
                end else begin
                    txShift_r <= {txShift_r[6:0], 1'b0};
                    sdaLow_r <= !txShift_r[6];
                end
            end
        end else if (state_r == sbu_pkg::ST_ACK && !ctrl_r.trx && !sclFall
                     && (addressed_r || zeroAddr_r || ackMode_r)) begin
            sdaLow_r <= 1'b1;
        end else if (sclFall) begin
            sdaLow_r <= 1'b0;
        end
    end

    // outputs from flops, inverted where active low; pad data tied low
    assign regRdata = regRdata_r;
    assign sclOut = 1'b0;
    assign sclOe_n = ~sclHold_r;
    assign sdaOut = 1'b0;
    assign sdaOe_n = ~sdaLow_r;
    assign eventPending = ~ctrl_r.pin;
endmodule : sbu_slave_stop

// *** dv/sbu_slave_stop_monitor.sv ***
/* checker on the slave/stop block ports.
   assumes a bind onto every sbu_slave_stop instance, one clock domain. */
`timescale 1ns/100ps
module sbu_slave_stop_monitor #(
    parameter int TLOW_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe_n,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe_n,
    input wire logic eventPending
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] lowCnt_r;
    // cycles scl stays pulled once released; saturates to avoid wrap
    always_ff @(posedge ref_clk) begin
        if (rst || sclOe_n || eventPending) begin
            lowCnt_r <= 8'h00;
        end else if (lowCnt_r != 8'hff) begin
            lowCnt_r <= lowCnt_r + 8'h01;
        end
    end
    sequence ctl2Wr(v);
        regWr && regAddr == sbu_pkg::OFS_CTRL_TWO && regWdata[7:4] == v;
    endsequence
    sequence relWr;
        regWr && regAddr == sbu_pkg::OFS_CTRL_TWO && regWdata[4];
    endsequence
    a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (regRd && regAddr > sbu_pkg::OFS_OWN_ADDR
        |=> regRdata == 8'h00) else $error("unmapped read not zero");
    a_pads_low: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
        else $error("pad data not low");
    a_reset_idle: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> sclOe_n && sdaOe_n && !eventPending) else $error("reset state wrong");
    a_release_flag: assert property (relWr |-> ##[1:2] !eventPending)
        else $error("release flag write ignored");
    a_scl_held: assert property ($past(eventPending, 2) && $past(eventPending)
        && eventPending |-> !sclOe_n) else $error("scl not held while pending");
    a_tlow_low: assert property ($fell(eventPending) |-> !sclOe_n [*2])
        else $error("scl freed before low period");
    a_tlow_bound: assert property (lowCnt_r <= TLOW_CYCLES + 6)
        else $error("scl held too long after release");
    a_restart_quiet: assert property (ctl2Wr(4'h1) |=> sdaOe_n [*8])
        else $error("sda pulled during restart release");
    a_stop_release: assert property (ctl2Wr(4'hd) |-> ##[1:60] (sdaOe_n && sclOe_n))
        else $error("stop never released lines");
endmodule : sbu_slave_stop_monitor

bind sbu_slave_stop sbu_slave_stop_monitor #(.TLOW_CYCLES(TLOW_CYCLES)) i_mon (.ref_clk,
    .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sclIn, .sclOut, .sclOe_n,
    .sdaIn, .sdaOut, .sdaOe_n, .eventPending);

// *** dv/sbu_far_master.sv ***
/* behavioural far-side master on the two-wire bus.
   assumes pulled-up lines: a high output means released. */
`timescale 1ns/100ps
module sbu_far_master (
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic farScl,
    output logic farSda
);
    // ------------------------------------------------------------
    // bus tasks, 160 ns bit period
    // ------------------------------------------------------------
    initial begin
        farScl = 1'b1;
        farSda = 1'b1;
    end
    // bounded wait, the slave may stretch the low period
    task wait_scl;
        int n;
        n = 0;
        while (sclLine !== 1'b1 && n < 2000) begin
            #10;
            n++;
        end
    endtask : wait_scl
    // data set while scl low, sampled mid high
    task clk_bit(input logic b, output logic s);
        farSda = b;
        #40 farScl = 1'b1;
        wait_scl;
        #40 s = sdaLine;
        #40 farScl = 1'b0;
        #40;
    endtask : clk_bit
    task bus_start;
        farSda = 1'b1;
        farScl = 1'b1;
        #80 farSda = 1'b0;
        #80 farScl = 1'b0;
        #40;
    endtask : bus_start
    task put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask : put_byte
    task get_byte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(nack, s);
    endtask : get_byte
    task bus_stop;
        farSda = 1'b0;
        #40 farScl = 1'b1;
        wait_scl;
        #80 farSda = 1'b1;
        #80;
    endtask : bus_stop
endmodule : sbu_far_master

// *** dv/i2c_slave_stop_restart_tb.sv ***
/* self-checking bench: software tasks on the register port, far master.
   assumes a 50 MHz clock and a short low period parameter. */
`timescale 1ns/100ps
module i2c_slave_stop_restart_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic sclOe_n, sdaOe_n, farScl, farSda, eventPending;
    wire logic sclLine = sclOe_n & farScl;
    wire logic sdaLine = sdaOe_n & farSda;
    int miscompares = 0;
    int comparisons = 0;
    sbu_slave_stop #(.TLOW_CYCLES(4)) i_dut (.ref_clk, .rst, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .sclIn(sclLine), .sclOut(), .sclOe_n, .sdaIn(sdaLine),
        .sdaOut(), .sdaOe_n, .eventPending);
    sbu_far_master i_far (.sclLine, .sdaLine, .farScl, .farSda);
    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #1000000;
        miscompares++;
        close_out;
    end
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge ref_clk) regWr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk) {regRd, regAddr} <= {1'b1, a};
        @(posedge ref_clk) regRd <= 1'b0;
        @(negedge ref_clk) d = regRdata;
    endtask : rd
    task wait_evt;
        int n;
        n = 0;
        while (eventPending !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        check("event pending", {7'h00, eventPending}, 8'h01);
    endtask : wait_evt
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] st, d, dat;
        logic [6:0] adr;
        logic ack;
        void'($urandom(32'h39e3));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(sbu_pkg::OFS_STATUS, st);
        check("status after reset", st & 8'hf0, 8'h10);
        rd(4'h2, d);
        check("unmapped read", d, 8'h00);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            adr = (k == 0) ? 7'h7f : 7'($urandom_range(1, 127));
            dat = (k == 0) ? 8'h00 : 8'($urandom);
            wr(sbu_pkg::OFS_OWN_ADDR, {adr, 1'b0});
            i_far.bus_start;
            i_far.put_byte({adr, 1'b0}, ack);
            check("write address ack", {7'h00, ack}, 8'h00);
            wait_evt;
            rd(sbu_pkg::OFS_STATUS, st);
            check("status write address", {2'b00, st[7:2]}, 8'h09);
            rd(sbu_pkg::OFS_DATA_BUF, d);
            i_far.put_byte(dat, ack);
            wait_evt;
            rd(sbu_pkg::OFS_STATUS, st);
            check("status data word", {2'b00, st[7:2]}, 8'h08);
            rd(sbu_pkg::OFS_DATA_BUF, d);
            check("received byte", d, dat);
            i_far.bus_stop;
            repeat (8) @(posedge ref_clk);
            rd(sbu_pkg::OFS_STATUS, st);
            check("busy after stop", {7'h00, st[5]}, 8'h00);
            i_far.bus_start;
            i_far.put_byte({adr, 1'b1}, ack);
            wait_evt;
            rd(sbu_pkg::OFS_STATUS, st);
            check("status read address", {2'b00, st[7:2]}, 8'h19);
            wr(sbu_pkg::OFS_DATA_BUF, ~dat);
            i_far.get_byte(d, 1'b1);
            check("sent byte", d, ~dat);
            wait_evt;
            rd(sbu_pkg::OFS_STATUS, st);
            check("status after nack", {4'h0, st[6], st[3], st[2], st[0]}, 8'h09);
            wr(sbu_pkg::OFS_CTRL_TWO, 8'h10);
            i_far.bus_stop;
            repeat (8) @(posedge ref_clk);
            $display("test transfer %0d done", k);
        end
        wr(sbu_pkg::OFS_CTRL_TWO, 8'h10);
        repeat (6) @(posedge ref_clk);
        check("lines after restart release", {6'h00, sclLine, sdaLine}, 8'h03);
        rd(sbu_pkg::OFS_STATUS, st);
        check("busy after restart release", {7'h00, st[5]}, 8'h00);
        for (int n = 0; n < 50 && st[5]; n++) rd(sbu_pkg::OFS_STATUS, st);
        for (int n = 0; n < 50 && !st[0]; n++) rd(sbu_pkg::OFS_STATUS, st);
        check("last bit before restart", {7'h00, st[0]}, 8'h01);
        // setup wait before the stop request
        repeat (sbu_pkg::TLOW_CYC) @(posedge ref_clk);
        wr(sbu_pkg::OFS_CTRL_ONE, 8'h10);
        rd(sbu_pkg::OFS_CTRL_ONE, d);
        check("ack mode selected", d, 8'h10);
        // master already zero: next write sets it, never zero again
        wr(sbu_pkg::OFS_CTRL_TWO, 8'hd0);
        // control left alone for 60 cycles; bus not busy, so no stop is generated
        repeat (60) @(posedge ref_clk);
        check("lines after stop request", {6'h00, sclLine, sdaLine}, 8'h03);
        $display("test restart and stop done");
        close_out;
    end
endmodule : i2c_slave_stop_restart_tb
